// ===== design/_unused_placeholder_removed.v
// holds no logic; the detector and its timer have their own files

// ===== design/adc_window_defs.vh
// constants shared by the window detector and its conversion timer
`ifndef ADC_WINDOW_DEFS_VH
`define ADC_WINDOW_DEFS_VH

// special register addresses
`define ADDR_GREATER_LIMIT_LOW  8'hc3
`define ADDR_GREATER_LIMIT_HIGH 8'hc4
`define ADDR_LESS_LIMIT_LOW     8'hc5
`define ADDR_LESS_LIMIT_HIGH    8'hc6
`define ADDR_RESULT_LOW_BYTE    8'hbd
`define ADDR_RESULT_HIGH_BYTE   8'hbe
`define ADDR_CONTROL            8'he8

// reset values
`define RST_GREATER_LIMIT       8'hff
`define RST_LESS_LIMIT          8'h00
`define RST_RESULT_BYTE         8'h00
`define RST_BYTE_ZERO           8'h00

// control register bit positions
`define CTRL_BUSY_BIT           4
`define CTRL_WINDOW_FLAG_BIT    3
`define CTRL_LEFT_JUSTIFY_BIT   2

// justification padding
`define JUSTIFY_PAD             4'h0

// conversion timing
`define SAR_CYCLES_PER_CONV     4'hd
`define SAR_BIT_LAST            4'hc
`define SAR_DIV_ZERO            5'h00
`define SAR_BIT_ZERO            4'h0
`define SAR_DIV_STEP            5'h01
`define SAR_BIT_STEP            4'h1

`endif

// ===== design/adc_window_detector.v
// window comparator with limit registers and result register
// the sar clock period is (sarDivider + 1) core cycles, so a
// conversion keeps convBusy high for 2 + 13 * (sarDivider + 1) cycles.
// reads return data one cycle after the read strobe.
// a start written while a conversion runs is dropped by the timer.
// the flag is decided on the word being loaded, so flag and result
// change on the same edge and software never sees them disagree.
// control bits 7..5 and 1..0 are not kept and read as zero.
// software may preload the result bytes between conversions.
`timescale 1ns/1ps
`include "adc_window_defs.vh"

module adc_window_detector (
	input  wire        mclk,
	input  wire        nrst,
	input  wire [7:0]  sfrAddr,
	input  wire [7:0]  sfrWrData,
	input  wire        sfrWr,
	input  wire        sfrRd,
	input  wire [4:0]  sarDivider,
	input  wire [11:0] sarResult,
	output reg  [7:0]  sfrRdData,
	output reg         windowMatchFlag,
	output wire        convBusy,
	output wire        convDone
);
	// limit registers
	reg [7:0]  greaterLimitLow_ff;
	reg [7:0]  greaterLimitHigh_ff;
	reg [7:0]  lessLimitLow_ff;
	reg [7:0]  lessLimitHigh_ff;

	// result and control state
	reg [7:0]  resultLowByte_ff;
	reg [7:0]  resultHighByte_ff;
	reg        leftJustifySelect_ff;

	// combinational helpers
	wire [15:0] greaterLimit;
	wire [15:0] lessLimit;
	wire [15:0] newWord;
	wire        startPulse;
	wire        ctrlWrite;
	reg         windowHit;
	reg  [7:0]  nxt_rdData;

	// place a 12-bit conversion word as the result register holds it
	function [15:0] justify;
		input [11:0] word;
		input        leftSel;
		begin
			if (leftSel) begin
				justify = {word, `JUSTIFY_PAD};
			end else begin
				justify = {`JUSTIFY_PAD, word};
			end
		end
	endfunction

	// address match used by every register decode
	function hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	assign greaterLimit = {greaterLimitHigh_ff, greaterLimitLow_ff};
	assign lessLimit    = {lessLimitHigh_ff, lessLimitLow_ff};

	// incoming word justified like the result register
	assign newWord = justify(sarResult, leftJustifySelect_ff);

	// writing one to the busy bit starts a conversion
	assign ctrlWrite  = sfrWr && hit(sfrAddr, `ADDR_CONTROL);
	assign startPulse = ctrlWrite && sfrWrData[`CTRL_BUSY_BIT];

	conversion_timer u_timer (
		.mclk       (mclk),
		.nrst       (nrst),
		.startPulse (startPulse),
		.sarDivider (sarDivider),
		.convBusy   (convBusy),
		.convDone   (convDone)
	);

	// window decision on the word about to be stored
	always @* begin
		windowHit = 1'b0;
		if (lessLimit > greaterLimit) begin
			windowHit = (newWord > greaterLimit) && (newWord < lessLimit);
		end else begin
			windowHit = (newWord > greaterLimit) || (newWord < lessLimit);
		end
	end

	// greater-than limit bytes
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			greaterLimitLow_ff  <= `RST_GREATER_LIMIT;
			greaterLimitHigh_ff <= `RST_GREATER_LIMIT;
		end else if (sfrWr) begin
			if (hit(sfrAddr, `ADDR_GREATER_LIMIT_LOW)) begin
				greaterLimitLow_ff <= sfrWrData;
			end else if (hit(sfrAddr, `ADDR_GREATER_LIMIT_HIGH)) begin
				greaterLimitHigh_ff <= sfrWrData;
			end
		end
	end

	// less-than limit bytes
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lessLimitLow_ff  <= `RST_LESS_LIMIT;
			lessLimitHigh_ff <= `RST_LESS_LIMIT;
		end else if (sfrWr) begin
			if (hit(sfrAddr, `ADDR_LESS_LIMIT_LOW)) begin
				lessLimitLow_ff <= sfrWrData;
			end else if (hit(sfrAddr, `ADDR_LESS_LIMIT_HIGH)) begin
				lessLimitHigh_ff <= sfrWrData;
			end
		end
	end

	// result register; a finishing conversion wins over a software write
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			resultLowByte_ff  <= `RST_RESULT_BYTE;
			resultHighByte_ff <= `RST_RESULT_BYTE;
		end else if (convDone) begin
			resultLowByte_ff  <= newWord[7:0];
			resultHighByte_ff <= newWord[15:8];
		end else if (sfrWr) begin
			if (hit(sfrAddr, `ADDR_RESULT_LOW_BYTE)) begin
				resultLowByte_ff <= sfrWrData;
			end else if (hit(sfrAddr, `ADDR_RESULT_HIGH_BYTE)) begin
				resultHighByte_ff <= sfrWrData;
			end
		end
	end

	// justify select lives in the control register
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			leftJustifySelect_ff <= 1'b0;
		end else if (ctrlWrite) begin
			leftJustifySelect_ff <= sfrWrData[`CTRL_LEFT_JUSTIFY_BIT];
		end
	end

	// sticky match flag; a match in the clearing cycle wins
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			windowMatchFlag <= 1'b0;
		end else if (convDone && windowHit) begin
			windowMatchFlag <= 1'b1;
		// apart from reset, only a software write clears it
		end else if (ctrlWrite) begin
			windowMatchFlag <= sfrWrData[`CTRL_WINDOW_FLAG_BIT];
		end
	end

	// read multiplexer; unmapped addresses read zero
	always @* begin
		nxt_rdData = `RST_BYTE_ZERO;
		if (hit(sfrAddr, `ADDR_GREATER_LIMIT_LOW)) begin
			nxt_rdData = greaterLimitLow_ff;
		end else if (hit(sfrAddr, `ADDR_GREATER_LIMIT_HIGH)) begin
			nxt_rdData = greaterLimitHigh_ff;
		end else if (hit(sfrAddr, `ADDR_LESS_LIMIT_LOW)) begin
			nxt_rdData = lessLimitLow_ff;
		end else if (hit(sfrAddr, `ADDR_LESS_LIMIT_HIGH)) begin
			nxt_rdData = lessLimitHigh_ff;
		end else if (hit(sfrAddr, `ADDR_RESULT_LOW_BYTE)) begin
			nxt_rdData = resultLowByte_ff;
		end else if (hit(sfrAddr, `ADDR_RESULT_HIGH_BYTE)) begin
			nxt_rdData = resultHighByte_ff;
		end else if (hit(sfrAddr, `ADDR_CONTROL)) begin
			nxt_rdData[`CTRL_BUSY_BIT]         = convBusy;
			nxt_rdData[`CTRL_WINDOW_FLAG_BIT]  = windowMatchFlag;
			nxt_rdData[`CTRL_LEFT_JUSTIFY_BIT] = leftJustifySelect_ff;
		end
	end

	// registered read data, held between reads
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sfrRdData <= `RST_BYTE_ZERO;
		end else if (sfrRd) begin
			sfrRdData <= nxt_rdData;
		end
	end
endmodule

// ===== design/conversion_timer.v
// conversion sequencer: begin cycle, sar clock periods, finish cycle
`timescale 1ns/1ps
`include "adc_window_defs.vh"

module conversion_timer (
	input  wire       mclk,
	input  wire       nrst,
	input  wire       startPulse,
	input  wire [4:0] sarDivider,
	output reg        convBusy,
	output reg        convDone
);
	localparam [3:0] ST_IDLE   = 4'h1;
	localparam [3:0] ST_BEGIN  = 4'h2;
	localparam [3:0] ST_SAR    = 4'h4;
	localparam [3:0] ST_FINISH = 4'h8;

	reg [3:0] state_ff;
	reg [4:0] divCnt_ff;
	reg [3:0] bitCnt_ff;

	// sequencer; a start while busy is ignored
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_ff  <= ST_IDLE;
			divCnt_ff <= `SAR_DIV_ZERO;
			bitCnt_ff <= `SAR_BIT_ZERO;
			convBusy  <= 1'b0;
			convDone  <= 1'b0;
		end else begin
			convDone <= 1'b0;
			case (state_ff)
				ST_IDLE: begin
					if (startPulse) begin
						state_ff <= ST_BEGIN;
						convBusy <= 1'b1;
					end
				end
				ST_BEGIN: begin
					state_ff  <= ST_SAR;
					divCnt_ff <= `SAR_DIV_ZERO;
					bitCnt_ff <= `SAR_BIT_ZERO;
				end
				ST_SAR: begin
					if (divCnt_ff == sarDivider) begin
						divCnt_ff <= `SAR_DIV_ZERO;
						if (bitCnt_ff == `SAR_BIT_LAST) begin
							state_ff <= ST_FINISH;
						end else begin
							bitCnt_ff <= bitCnt_ff + `SAR_BIT_STEP;
						end
					end else begin
						divCnt_ff <= divCnt_ff + `SAR_DIV_STEP;
					end
				end
				ST_FINISH: begin
					state_ff <= ST_IDLE;
					convBusy <= 1'b0;
					convDone <= 1'b1;
				end
				default: begin
					state_ff <= ST_IDLE;
					convBusy <= 1'b0;
				end
			endcase
		end
	end
endmodule

// ===== testbench/adc_window_detector_monitor.sv
// port assertions for the window detector
`timescale 1ns/1ps
module adc_window_detector_monitor (
	input wire		mclk,
	input wire		nrst,
	input wire [7:0]	sfrAddr,
	input wire [7:0]	sfrWrData,
	input wire		sfrWr,
	input wire		sfrRd,
	input wire [4:0]	sarDivider,
	input wire [11:0]	sarResult,
	input wire [7:0]	sfrRdData,
	input wire		windowMatchFlag,
	input wire		convBusy,
	input wire		convDone
);
	reg [8:0]	busyCnt_ff;
	wire		ctlWr = sfrWr && sfrAddr == 8'he8;
	wire		startWr = ctlWr && sfrWrData[4];
	wire		setWr = ctlWr && sfrWrData[3];
	wire		clrWr = ctlWr && !sfrWrData[3];
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// busy cycle count
	always @(posedge mclk or negedge nrst)
		if (!nrst)
			busyCnt_ff <= 9'h000;
		else
			busyCnt_ff <= convBusy ? busyCnt_ff + 9'h001 : 9'h000;
	busy_len_a: assert property ($fell(convBusy) |-> busyCnt_ff == 13 * sarDivider + 15)
		else $error("bad length");
	done_after_a: assert property (convDone |-> !convBusy && $past(convBusy))
		else $error("bad done");
	done_pulse_a: assert property (convDone |=> !convDone)
		else $error("long done");
	start_busy_a: assert property (startWr && !convBusy |=> convBusy)
		else $error("no start");
	busy_cause_a: assert property ($rose(convBusy) |-> $past(startWr))
		else $error("stray start");
	flag_clear_a: assert property ($fell(windowMatchFlag) |-> $past(clrWr))
		else $error("flag dropped");
	flag_set_a: assert property ($rose(windowMatchFlag) |-> $past(convDone) || $past(setWr))
		else $error("stray flag");
	read_hold_a: assert property (!sfrRd |=> $stable(sfrRdData))
		else $error("read data moved");
	cover property ($rose(windowMatchFlag));
	cover property ($fell(windowMatchFlag));
	cover property (convDone);
endmodule
bind adc_window_detector adc_window_detector_monitor i_mon (.mclk(mclk), .nrst(nrst),
	.sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd),
	.sarDivider(sarDivider), .sarResult(sarResult), .sfrRdData(sfrRdData),
	.windowMatchFlag(windowMatchFlag), .convBusy(convBusy), .convDone(convDone));

// ===== testbench/adc_window_detector_test.sv
// self-checking bench for the window detector
`timescale 1ns/1ps
module adc_window_detector_test;
	reg		mclk = 1'b0, nrst = 1'b0, sfrWr = 1'b0, sfrRd = 1'b0;
	reg [7:0]	sfrAddr = 8'h00, sfrWrData = 8'h00;
	reg [4:0]	sarDivider = 5'h00;
	reg [11:0]	sarResult = 12'h000;
	wire [7:0]	sfrRdData;
	wire		windowMatchFlag, convBusy, convDone;
	integer		n_mismatch = 0, check_count = 0, cyc = 0, seed = 32'h9735;
	integer		i, j, k, gt, lt, lj, flg, r, w, dv, ex;
	int		expq[$];
	adc_window_detector i_dut (.mclk(mclk), .nrst(nrst), .sfrAddr(sfrAddr),
		.sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd), .sarDivider(sarDivider),
		.sarResult(sarResult), .sfrRdData(sfrRdData), .windowMatchFlag(windowMatchFlag),
		.convBusy(convBusy), .convDone(convDone));
	initial begin
		forever #25 mclk = ~mclk;
	end
	// hang guard
	always @(posedge mclk) begin
		cyc = cyc + 1;
		if (cyc == 6000) begin
			n_mismatch = n_mismatch + 1;
			report_and_stop;
		end
	end
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string s, input [15:0] e, input [15:0] g);
		check_count = check_count + 1;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", s, e, g);
			n_mismatch = n_mismatch + 1;
		end
	endtask
	// one bus cycle; a read compares with d
	task acc(input wr, input [7:0] a, input [7:0] d);
		@(posedge mclk);
		sfrWr <= wr;
		sfrRd <= !wr;
		sfrAddr <= a;
		sfrWrData <= d;
		@(posedge mclk);
		sfrWr <= 1'b0;
		sfrRd <= 1'b0;
		#1 if (!wr) chk("read", {8'h00, d}, {8'h00, sfrRdData});
	endtask
	// one conversion against the model
	task conv(input [11:0] v, input clr);
		r = $random(seed);
		dv = 15 + 13 * r[1:0];
		@(posedge mclk);
		sarDivider <= r[4:0] & 5'h03;
		sarResult <= v;
		acc(1, 8'he8, {3'h0, 1'b1, flg[0] & !clr, lj[0], 2'h0});
		if (clr)
			flg = 0;
		for (k = 0; k < 100 && convDone !== 1'b1; k = k + 1)
			@(posedge mclk) #1;
		chk("cycles", dv[15:0], k[15:0]);
		r = lj ? {v, 4'h0} : {4'h0, v};
		expq.push_back(r);
		if (lt > gt ? r > gt && r < lt : r > gt || r < lt)
			flg = 1;
		@(posedge mclk) #1;
		chk("flag", {15'h0, flg[0]}, {15'h0, windowMatchFlag});
		ex = expq.pop_front();
		acc(0, 8'hbd, ex[7:0]);
		acc(0, 8'hbe, ex[15:8]);
		acc(0, 8'he8, {3'h0, 1'b0, flg[0], lj[0], 2'h0});
	endtask
	initial begin
		flg = 0;
		lj = 0;
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		acc(0, 8'hc3, 8'hff);
		acc(0, 8'hc4, 8'hff);
		acc(0, 8'hc5, 8'h00);
		acc(0, 8'hc6, 8'h00);
		acc(0, 8'h00, 8'h00);
		// inside, outside, left justified, random limits
		for (i = 0; i < 4; i = i + 1) begin
			lj = i == 2;
			gt = i == 1 ? 16'h0200 : i == 2 ? 16'h1000 : 16'h0100;
			lt = i == 1 ? 16'h0100 : i == 2 ? 16'h2000 : 16'h0200;
			if (i == 3) begin
				gt = $random(seed) & 16'h0fff;
				lt = $random(seed) & 16'h0fff;
			end
			for (j = 0; j < 4; j = j + 1) begin
				w = j < 2 ? gt : lt;
				acc(1, 8'hc3 + j[7:0], j[0] ? w[15:8] : w[7:0]);
				acc(0, 8'hc3 + j[7:0], j[0] ? w[15:8] : w[7:0]);
			end
			for (j = 0; j < 8; j = j + 1) begin
				w = (j < 3 ? gt : lt) >> (lj * 4);
				w = j < 6 ? w + j % 3 - 1 : $random(seed);
				conv(w[11:0], j[0]);
			end
		end
		// software sets and clears the match flag
		acc(1, 8'he8, 8'h08);
		acc(0, 8'he8, 8'h08);
		acc(1, 8'he8, 8'h00);
		chk("flag", 16'h0000, {15'h0, windowMatchFlag});
		// unmapped write ignored, result bytes preloadable
		acc(1, 8'h00, 8'h5a);
		acc(0, 8'h00, 8'h00);
		acc(1, 8'hbd, 8'h3c);
		acc(0, 8'hbd, 8'h3c);
		// reset again with altered limits
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		acc(0, 8'hc3, 8'hff);
		acc(0, 8'hc4, 8'hff);
		acc(0, 8'hc6, 8'h00);
		report_and_stop;
	end
endmodule
